// ---- design/cphc_pkg.sv ----
`default_nettype none
package cphc_pkg;
   // Bit positions inside configuration byte 0FH
   localparam int unsigned CLAMP_SEL_BIT   = 7;
   localparam int unsigned CLAMP_SENSE_BIT = 6;
   localparam int unsigned HOLD_SENSE_BIT  = 3;
   // Bit position inside configuration byte 0EH
   localparam int unsigned SYNC_SENSE_BIT  = 6;
   // Reset values of the control bits
   localparam logic CLAMP_SEL_RST   = 1'b0;
   localparam logic CLAMP_SENSE_RST = 1'b1;
   localparam logic HOLD_SENSE_RST  = 1'b1;
   localparam logic SYNC_SENSE_RST  = 1'b1;
   // Internal clamp timing counter width and defaults (pixel clocks)
   localparam int unsigned CNT_W         = 8;
   localparam logic [7:0]  CLAMP_DLY_RST = 8'h04;
   localparam logic [7:0]  CLAMP_DUR_RST = 8'h14;
   // Internal clamp sequencer states
   typedef enum logic [1:0] {
      CPHC_IDLE  = 2'b00,
      CPHC_DELAY = 2'b01,
      CPHC_CLAMP = 2'b10
   } cphc_state_t;
endpackage : cphc_pkg
`default_nettype wire

// ---- design/cphc_edge.sv ----
`default_nettype none
// Polarity-corrected edge detector; one cycle pulses on lead and trail
module cphc_edge (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic srst_i,
   // Raw level and its active sense
   input  wire logic level_i,
   input  wire logic sense_i,
   // Active level and edge pulses
   output logic      active_o,
   output logic      lead_o,
   output logic      trail_o
);
   logic prev_q;

   // Level normalised so that 1 means asserted
   assign active_o = level_i ~^ sense_i;

   // Previous sample for edge detection
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= active_o;
      end
   end

   assign lead_o  = active_o & ~prev_q;
   assign trail_o = ~active_o & prev_q;
endmodule : cphc_edge
`default_nettype wire

// ---- design/cphc_top.sv ----
`default_nettype none
// Operation
// R1 - External clamp used only when select bit set
// R2 - Select clear: internal delay then duration timing
// R3 - Clamp sense bit sets external clamp level
// R4 - Source clamps only during back porch reference
// R5 - Unused clamp tied low, select programmed zero
// R6 - Hold active: stop tracking, keep frequency, phase
// R7 - Hold sense bit sets hold active level
// R8 - Hold sense resets to one
// R9 - Unused hold pin kept inactive via sense
// R10 - Only sync leading edge drives clock generation
// R11 - Clamp counts in pixel clocks, restart per trail
module cphc_top
   import cphc_pkg::*;
(
   // Pixel clock and reset
   input  wire logic                            clk_i,
   input  wire logic                            srst_i,
   // Configuration byte writes (0EH, 0FH) and timing values
   input  wire logic                            cfg0e_we_i,
   input  wire logic [7:0]                      cfg0e_i,
   input  wire logic                            cfg0f_we_i,
   input  wire logic [7:0]                      cfg0f_i,
   input  wire logic [cphc_pkg::CNT_W-1:0]      clamp_dly_i,
   input  wire logic [cphc_pkg::CNT_W-1:0]      clamp_dur_i,
   // Pins from the graphics source
   input  wire logic                            line_sync_i,
   input  wire logic                            ext_clamp_i,
   input  wire logic                            hold_i,
   // Outputs to analog front end and clock generator
   output logic                                 clamp_o,
   output logic                                 pll_ref_o,
   output logic                                 pll_hold_o
);
   import cphc_pkg::*;

   logic clamp_sel_q, clamp_sense_q, hold_sense_q, sync_sense_q;
   logic sync_act, sync_lead, sync_trail;
   logic ext_act, hold_act;
   logic [CNT_W-1:0] cnt_q, dly_q, dur_q;
   cphc_state_t      state_q;

   // Pin is asserted when its level equals its sense bit
   function automatic logic pin_active(input logic pin, input logic sense);
      return pin ~^ sense;
   endfunction : pin_active

   // Phase done once the next count reaches the limit; a zero limit
   // ends after one cycle, so a phase can never stall
   function automatic logic cnt_done(input logic [CNT_W-1:0] cnt,
                                     input logic [CNT_W-1:0] lim);
      return ({1'b0, cnt} + {{CNT_W{1'b0}}, 1'b1}) >= {1'b0, lim};
   endfunction : cnt_done

   ////////////////////////////////////////////////////////////////////////
   // Control bits, defined after reset
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         clamp_sel_q   <= CLAMP_SEL_RST;               // [R1]
         clamp_sense_q <= CLAMP_SENSE_RST;
         hold_sense_q  <= HOLD_SENSE_RST;              // [R8]
         sync_sense_q  <= SYNC_SENSE_RST;
      end else begin
         if (cfg0f_we_i) begin
            clamp_sel_q   <= cfg0f_i[CLAMP_SEL_BIT];
            clamp_sense_q <= cfg0f_i[CLAMP_SENSE_BIT];
            hold_sense_q  <= cfg0f_i[HOLD_SENSE_BIT];
         end
         if (cfg0e_we_i) begin
            sync_sense_q  <= cfg0e_i[SYNC_SENSE_BIT];
         end
      end
   end

   // Timing values latched so a mid-line change waits for the next line
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         dly_q <= CLAMP_DLY_RST;
         dur_q <= CLAMP_DUR_RST;
      end else if (sync_trail) begin
         dly_q <= clamp_dly_i;
         dur_q <= clamp_dur_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Line sync edges under programmed sense
   cphc_edge u_sync_edge (
      .clk_i    (clk_i),
      .srst_i   (srst_i),
      .level_i  (line_sync_i),
      .sense_i  (sync_sense_q),
      .active_o (sync_act),
      .lead_o   (sync_lead),
      .trail_o  (sync_trail)
   );

   // Pin senses: active when pin equals its sense bit
   assign ext_act  = pin_active(ext_clamp_i, clamp_sense_q); // [R3]
   assign hold_act = pin_active(hold_i, hold_sense_q);       // [R7] [R9]

   ////////////////////////////////////////////////////////////////////////
   // Internal clamp sequencer, restarts at every trailing edge
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_q <= CPHC_IDLE;
         cnt_q   <= '0;
      end else if (sync_trail) begin                   // [R11]
         // The delay latched at this edge governs this line, not the old one
         state_q <= (clamp_dly_i == '0) ? CPHC_CLAMP : CPHC_DELAY;
         cnt_q   <= '0;
      end else begin
         unique case (state_q)
            CPHC_IDLE: begin
               cnt_q <= '0;
            end
            CPHC_DELAY: begin
               if (cnt_done(cnt_q, dly_q)) begin       // [R2]
                  state_q <= CPHC_CLAMP;
                  cnt_q   <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            CPHC_CLAMP: begin
               if (cnt_done(cnt_q, dur_q)) begin       // [R2]
                  state_q <= CPHC_IDLE;
                  cnt_q   <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            default: begin
               state_q <= CPHC_IDLE;
               cnt_q   <= '0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clamp source mux; the external pin is ignored when not selected
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         clamp_o <= 1'b0;
      end else if (clamp_sel_q) begin
         clamp_o <= ext_act;                           // [R1] [R4] [R5]
      end else begin
         clamp_o <= (state_q == CPHC_CLAMP);           // [R2]
      end
   end

   // Hold freezes the reference so the generator free-runs
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pll_hold_o <= 1'b0;
         pll_ref_o  <= 1'b0;
      end else begin
         pll_hold_o <= hold_act;                       // [R6]
         pll_ref_o  <= sync_lead & ~hold_act;          // [R6] [R10]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_ext_clamp_follow: assert property ( // [R1]
      @(posedge clk_i) disable iff (srst_i)
      clamp_sel_q && $past(clamp_sel_q) |-> clamp_o == $past(ext_act))
      else $error("clamp output does not follow external pin");

   a_ext_ignored: assert property ( // [R2]
      @(posedge clk_i) disable iff (srst_i)
      !clamp_sel_q && $past(!clamp_sel_q) |->
         clamp_o == ($past(state_q) == CPHC_CLAMP))
      else $error("internal clamp timing not used");

   a_clamp_sense: assert property ( // [R3]
      @(posedge clk_i) disable iff (srst_i)
      clamp_sel_q && $past(clamp_sel_q) |->
         clamp_o == ($past(ext_clamp_i) == $past(clamp_sense_q)))
      else $error("clamp sense wrong");

   a_hold_no_ref: assert property ( // [R6]
      @(posedge clk_i) disable iff (srst_i)
      hold_act |=> !pll_ref_o && pll_hold_o)
      else $error("reference pulse during hold");

   a_hold_sense: assert property ( // [R7]
      @(posedge clk_i) disable iff (srst_i)
      !$past(srst_i) |->
         pll_hold_o == ($past(hold_i) == $past(hold_sense_q)))
      else $error("hold sense wrong");

   a_hold_sense_rst: assert property ( // [R8]
      @(posedge clk_i) srst_i |=> hold_sense_q)
      else $error("hold sense not one after reset");

   // Edge history is cleared by reset, so skip the edge right after it
   a_lead_only: assert property ( // [R10]
      @(posedge clk_i) disable iff (srst_i)
      pll_ref_o && !$past(srst_i, 2) |->
         $past(sync_act) && !$past(sync_act, 2))
      else $error("reference not from leading edge");

   a_delay_start: assert property ( // [R11]
      @(posedge clk_i) disable iff (srst_i)
      sync_trail && clamp_dly_i != '0 |=>
         state_q == CPHC_DELAY && cnt_q == '0)
      else $error("clamp count not restarted");

   a_dly_zero: assert property ( // [R2]
      @(posedge clk_i) disable iff (srst_i)
      sync_trail && clamp_dly_i == '0 |=>
         state_q == CPHC_CLAMP && cnt_q == '0)
      else $error("zero delay does not clamp at once");

   a_delay_bound: assert property ( // [R11]
      @(posedge clk_i) disable iff (srst_i)
      state_q == CPHC_DELAY |-> cnt_q < dly_q)
      else $error("clamp delay overran");

   a_clamp_bound: assert property ( // [R11]
      @(posedge clk_i) disable iff (srst_i)
      state_q == CPHC_CLAMP |-> cnt_q < dur_q || cnt_q == '0)
      else $error("clamp duration overran");

   a_ref_single: assert property ( // [R10]
      @(posedge clk_i) disable iff (srst_i)
      pll_ref_o |=> !pll_ref_o)
      else $error("reference pulse longer than one cycle");

   a_ref_passes: assert property ( // [R6]
      @(posedge clk_i) disable iff (srst_i)
      !hold_act |=> pll_ref_o == $past(sync_lead))
      else $error("leading edge lost outside hold");
endmodule : cphc_top
`default_nettype wire

// ---- verification/cphc_src.sv ----
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Graphics source: 40-cycle lines, back porch clamp, hold on request
module cphc_src (
   // Clock
   input  wire logic clk_i,
   // Pin senses and hold request
   input  wire logic spol_i,
   input  wire logic cpol_i,
   input  wire logic hpol_i,
   input  wire logic hold_on_i,
   input  wire logic clamp_use_i,
   // Pins into the block
   output logic      line_sync_o,
   output logic      ext_clamp_o,
   output logic      hold_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned pos = 0;
   // Pins move on the falling edge, clear of sampling
   always @(negedge clk_i) begin
      pos = (pos + 1) % 40;
      line_sync_o <= (pos < 4) ~^ spol_i;
      // An unused clamp pin stays grounded
      ext_clamp_o <= clamp_use_i
                     & ((pos > 5 && pos < 12) ~^ cpol_i);
      hold_o      <= hold_on_i ~^ hpol_i;
   end
endmodule : cphc_src
`default_nettype wire

// ---- verification/tb_top.sv ----
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import cphc_pkg::*;
   logic             clk_i = 0, srst_i = 1, we_e = 0, we_f = 0;
   logic             hold_on = 0, sync, extc, hold, clamp_o, ref_o, hold_o;
   logic [7:0]       b_e = 8'h40, b_f = 8'h48;
   logic [CNT_W-1:0] dly = '0, dur = '0;
   logic             sel, cs, hs, ss, ap;
   logic [2:0]       e, q[$];
   logic [31:0]      rs = 32'd86372;
   int unsigned      n, d, u, error_cnt = 0, tests_run = 0;
   ////////////////////////////////////////////////////////////////////
   cphc_top uut (.clk_i(clk_i), .srst_i(srst_i), .cfg0e_we_i(we_e),
      .cfg0e_i(b_e), .cfg0f_we_i(we_f), .cfg0f_i(b_f),
      .clamp_dly_i(dly), .clamp_dur_i(dur), .line_sync_i(sync),
      .ext_clamp_i(extc), .hold_i(hold), .clamp_o(clamp_o),
      .pll_ref_o(ref_o), .pll_hold_o(hold_o));
   cphc_src src (.clk_i(clk_i), .spol_i(b_e[6]), .cpol_i(b_f[6]),
      .hpol_i(b_f[3]), .hold_on_i(hold_on), .line_sync_o(sync),
      .ext_clamp_o(extc), .hold_o(hold),
      // Grounded only when internal timing runs and sense is low
      .clamp_use_i(b_f[CLAMP_SEL_BIT] | b_f[CLAMP_SENSE_BIT]));
   // 50 MHz clock
   initial forever #10 clk_i = ~clk_i;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   task automatic chk(input logic g, input logic x);
      tests_run++;
      if (g !== x) begin
         error_cnt++;
         $display("[ERR] %0t: output mismatch", $time);
      end
   endtask : chk
   task automatic finish_test;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   // Expected outputs after each edge; config seen one edge late
   always @(posedge clk_i) begin
      logic a;
      if (srst_i) begin
         {sel, cs, hs, ss, ap} = 5'b01110;
         n = 999;
      end else begin
         a = (sync == ss);
         if (!a && ap) begin
            n = 0;
            d = dly;
            u = (dur != 0) ? dur : 1;
         end else n++;
         q.push_back({sel ? extc == cs : (n > d && n <= d + u),
                      a && !ap && hold != hs, hold == hs});
         ap = a;
         if (we_e) ss = b_e[SYNC_SENSE_BIT];
         if (we_f) {sel, cs, hs} = {b_f[CLAMP_SEL_BIT],
            b_f[CLAMP_SENSE_BIT], b_f[HOLD_SENSE_BIT]};
      end
   end
   // Oldest note against settled outputs
   always @(posedge clk_i) begin
      #1;
      if (q.size() > 0) begin
         e = q.pop_front();
         chk(clamp_o, e[2]);
         chk(ref_o, e[1]);
         chk(hold_o, e[0]);
      end
   end
   // Every sense and source mode, random timing and hold
   initial begin
      repeat (12) @(negedge clk_i);
      srst_i = 0;
      for (int m = 0; m < 16; m++) begin
         @(negedge clk_i);
         {we_e, we_f} = 2'b11;
         b_e = {1'b0, m[3], 6'h00};
         b_f = {m[0], m[1], 2'b00, m[2], 3'b000};
         @(negedge clk_i);
         {we_e, we_f} = 2'b00;
         repeat (160) begin
            @(negedge clk_i);
            rs = xs(rs);
            dly = {4'h0, rs[3:0]};
            dur = {4'h0, rs[7:4]};
            if (rs[12:8] == 5'h00) hold_on = ~hold_on;
         end
      end
      finish_test();
   end
   // Hang guard, about twice the expected run
   initial begin
      #(20 * 6000);
      error_cnt++;
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
